// file: asr_defines.svh
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ASR_ADDR_TX_CTRL 4'h0
`define ASR_ADDR_RX_CTRL 4'h1
`define ASR_ADDR_TX_DATA 4'h2
`define ASR_ADDR_RX_DATA 4'h3
`define ASR_ADDR_IRQ_EN 4'h4
`define ASR_ADDR_STATUS 4'h5

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ASR_TXC_ENABLE 0
`define ASR_TXC_NINE 1
`define ASR_TXC_NINTH 2
`define ASR_TXC_INVERT 3
`define ASR_TXC_SYNC 4
`define ASR_TXC_PORT_EN 5
`define ASR_RXC_CONTINUOUS_RECEIVE_ENABLE 0
`define ASR_RXC_NINE 1
`define ASR_IE_TX 0
`define ASR_IE_RX 1
`define ASR_IE_PERIPHERAL_IRQ_GATE 2
`define ASR_IE_GIE 3
`define ASR_ST_SHIFT_EMPTY 0
`define ASR_ST_TX_FLAG 1
`define ASR_ST_RX_FLAG 2
`define ASR_ST_OVERRUN 3
`define ASR_ST_FRAMING 4
`define ASR_ST_RX_NINTH 5

// ---------------------------------------------------------------
// Timing counts, in baud ticks
// ---------------------------------------------------------------
`define ASR_OVERSAMPLE 5'd16
`define ASR_HALF_BIT 4'd7
`define ASR_LAST_TICK 4'hf

`endif

// file: asr_fifo_if.sv
interface asr_fifo_if;
    logic push;
    logic pop;
    logic flush;
    logic [9:0] wdata;
    logic [9:0] rdata;
    logic [1:0] count;
    modport owner (output push, output pop, output flush, output wdata,
                   input rdata, input count);
    modport store (input push, input pop, input flush, input wdata,
                   output rdata, output count);
endinterface

// file: asr_pkg.sv
package asr_pkg;
    typedef enum logic [1:0] {
        ASR_RX_IDLE,
        ASR_RX_START,
        ASR_RX_DATA,
        ASR_RX_STOP
    } asr_rx_state_t;
endpackage

// file: asr_remote_node.sv
module asr_remote_node (
    input wire logic core_clk,
    input wire logic baud_tick,
    input wire logic tx_out,
    output logic rx_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] seen [$];
    logic [8:0] sh;
    initial rx_in = 1'b1;
    task automatic ticks(int n);
        repeat (n) @(posedge core_clk iff baud_tick);
    endtask
    task automatic line(logic v);
        rx_in <= v;
        ticks(16);
    endtask
    task automatic send(logic [8:0] d, int n, logic stop);
        ticks(1);
        line(1'b0);
        for (int i = 0; i < n; i++) line(d[i]);
        line(stop);
        rx_in <= 1'b1;
    endtask
    // Start pulse too short to survive the mid-bit check
    task automatic blip(int n);
        ticks(1);
        rx_in <= 1'b0;
        ticks(n);
        rx_in <= 1'b1;
    endtask
    // ----
    // Receiver, nine mid-bit samples
    // ----
    always begin
        @(negedge tx_out);
        ticks(8);
        repeat (9) begin
            ticks(16);
            sh = {tx_out, sh[8:1]};
        end
        seen.push_back(sh);
    end
endmodule

// file: asr_rx_fifo.sv
`include "asr_defines.svh"

module asr_rx_fifo #(
    parameter int DEPTH = 2
) (
    input wire logic core_clk,
    input wire logic rstn,
    asr_fifo_if.store f
);
    typedef struct packed {
        logic [DEPTH-1:0][9:0] mem;
        logic rd_ptr;
        logic wr_ptr;
        logic [1:0] count;
    } asr_fifo_st_t;

    asr_fifo_st_t st_reg;
    asr_fifo_st_t st_next;

    always_comb begin
        st_next = st_reg;
        if (f.flush) begin
            st_next.rd_ptr = 1'b0;
            st_next.wr_ptr = 1'b0;
            st_next.count = 2'h0;
        end else begin
            if (f.push && st_reg.count != 2'(DEPTH)) begin
                st_next.mem[st_reg.wr_ptr] = f.wdata;
                st_next.wr_ptr = ~st_reg.wr_ptr;
            end
            if (f.pop && st_reg.count != 2'h0) begin
                st_next.rd_ptr = ~st_reg.rd_ptr;
            end
            st_next.count = st_reg.count
                + 2'((f.push && st_reg.count != 2'(DEPTH)) ? 1 : 0)
                - 2'((f.pop && st_reg.count != 2'h0) ? 1 : 0);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign f.rdata = st_reg.mem[st_reg.rd_ptr];
    assign f.count = st_reg.count;
endmodule

// file: asr_serial_port.sv
// Our own choices: the plain strobed port and the address map.
`include "asr_defines.svh"

module asr_serial_port (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic baud_tick,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic rx_in,
    output logic tx_out,
    output logic tx_irq,
    output logic rx_irq
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic tx_enable;
        logic tx_nine;
        logic tx_ninth;
        logic tx_invert;
        logic sync_mode;
        logic port_enable;
        logic continuous_receive_enable;
        logic rx_nine;
        logic [3:0] irq_en;
        logic [8:0] tx_buf;
        logic tx_buf_full;
        logic [10:0] tx_shift;
        logic [3:0] tx_bits;
        logic [3:0] tx_sub;
        logic tx_busy;
        logic tx_line;
        asr_pkg::asr_rx_state_t rx_state;
        logic [3:0] rx_sub;
        logic [3:0] rx_bits;
        logic [8:0] rx_shift;
        logic [4:0] votes;
        logic rx_prev;
        logic overrun;
        logic [7:0] rdata;
        logic tx_irq;
        logic rx_irq;
    } asr_state_t;

    asr_state_t s_reg;
    asr_state_t s_next;
    asr_fifo_if fi ();

    asr_rx_fifo #(.DEPTH(2)) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .f(fi.store)
    );

    function automatic logic reg_hit(input logic strobe, input logic [3:0] a,
                                     input logic [3:0] target);
        reg_hit = strobe && (a == target);
    endfunction

    logic shift_empty;
    logic tx_flag;
    logic rx_flag;
    logic rx_active;
    logic [9:0] fifo_top;
    logic [3:0] data_bits;
    logic bit_vote;

    always_comb begin
        shift_empty = !s_reg.tx_busy;
        tx_flag = s_reg.tx_enable && !s_reg.tx_buf_full;
        rx_active = s_reg.continuous_receive_enable && !s_reg.sync_mode
            && s_reg.port_enable;
        // Flag only while the receiver is enabled
        rx_flag = rx_active && fi.count != 2'h0;
        fifo_top = fi.rdata;
        data_bits = s_reg.rx_nine ? 4'd9 : 4'd8;
        bit_vote = s_reg.votes > 5'd1;
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        fi.push = 1'b0;
        fi.pop = 1'b0;
        fi.flush = !s_reg.port_enable;
        fi.wdata = '0;
        s_next.rdata = 8'h00;

        // Register writes
        if (reg_hit(wr_en, addr, `ASR_ADDR_TX_CTRL)) begin
            s_next.tx_enable = wdata[`ASR_TXC_ENABLE];
            s_next.tx_nine = wdata[`ASR_TXC_NINE];
            s_next.tx_ninth = wdata[`ASR_TXC_NINTH];
            s_next.tx_invert = wdata[`ASR_TXC_INVERT];
            s_next.sync_mode = wdata[`ASR_TXC_SYNC];
            s_next.port_enable = wdata[`ASR_TXC_PORT_EN];
        end
        if (reg_hit(wr_en, addr, `ASR_ADDR_RX_CTRL)) begin
            s_next.continuous_receive_enable = wdata[`ASR_RXC_CONTINUOUS_RECEIVE_ENABLE];
            s_next.rx_nine = wdata[`ASR_RXC_NINE];
        end
        if (reg_hit(wr_en, addr, `ASR_ADDR_IRQ_EN)) begin
            s_next.irq_en = wdata[3:0];
        end
        if (reg_hit(wr_en, addr, `ASR_ADDR_TX_DATA)
                && !s_reg.tx_buf_full) begin
            s_next.tx_buf = {s_reg.tx_ninth, wdata};
            s_next.tx_buf_full = 1'b1;
        end

        // Register reads
        if (rd_en) begin
            case (addr)
                `ASR_ADDR_TX_CTRL: begin
                    s_next.rdata = {2'b00, s_reg.port_enable, s_reg.sync_mode,
                        s_reg.tx_invert, s_reg.tx_ninth, s_reg.tx_nine,
                        s_reg.tx_enable};
                end
                `ASR_ADDR_RX_CTRL: begin
                    s_next.rdata = {6'h00, s_reg.rx_nine, s_reg.continuous_receive_enable};
                end
                `ASR_ADDR_IRQ_EN: begin
                    s_next.rdata = {4'h0, s_reg.irq_en};
                end
                `ASR_ADDR_RX_DATA: begin
                    s_next.rdata = fifo_top[7:0];
                    fi.pop = 1'b1;
                end
                `ASR_ADDR_STATUS: begin
                    s_next.rdata = {2'b00, fifo_top[8], fifo_top[9],
                        s_reg.overrun, rx_flag, tx_flag,
                        shift_empty};
                end
                default: begin
                    s_next.rdata = 8'h00;
                end
            endcase
        end

        // -----------------------------------------------------------
        // Transmitter
        // -----------------------------------------------------------
        if (!s_reg.port_enable || !s_reg.tx_enable) begin
            s_next.tx_busy = 1'b0;
            s_next.tx_line = 1'b1;
        end else if (!s_reg.tx_busy) begin
            s_next.tx_line = 1'b1;
            if (s_reg.tx_buf_full) begin
                // Stop, data LSB first, start
                s_next.tx_shift = {1'b1, s_reg.tx_buf, 1'b0};
                s_next.tx_bits = s_reg.tx_nine ? 4'd11 : 4'd10;
                if (!s_reg.tx_nine) begin
                    s_next.tx_shift[9] = 1'b1;
                end
                s_next.tx_sub = 4'h0;
                s_next.tx_busy = 1'b1;
                s_next.tx_buf_full = s_next.tx_buf_full
                    && reg_hit(wr_en, addr, `ASR_ADDR_TX_DATA);
            end
        end else if (baud_tick) begin
            if (s_reg.tx_sub == 4'h0) begin
                s_next.tx_line = s_reg.tx_shift[0];
                s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
            end
            s_next.tx_sub = s_reg.tx_sub + 4'h1;
            if (s_reg.tx_sub == `ASR_LAST_TICK) begin
                s_next.tx_bits = s_reg.tx_bits - 4'h1;
                if (s_reg.tx_bits == 4'h1) begin
                    s_next.tx_busy = 1'b0;
                end
            end
        end

        // -----------------------------------------------------------
        // Receiver
        // -----------------------------------------------------------
        if (!s_reg.continuous_receive_enable || !s_reg.port_enable) begin
            s_next.overrun = 1'b0;
        end
        // Edge detect at tick rate, line moves between ticks
        if (baud_tick) begin
            s_next.rx_prev = rx_in;
        end
        if (!rx_active || s_reg.overrun) begin
            s_next.rx_state = asr_pkg::ASR_RX_IDLE;
        end else if (baud_tick) begin
            s_next.rx_sub = s_reg.rx_sub + 4'h1;
            if (s_reg.rx_sub >= 4'd6 && s_reg.rx_sub <= 4'd8) begin
                s_next.votes = s_reg.votes + {4'h0, rx_in};
            end
            case (s_reg.rx_state)
                asr_pkg::ASR_RX_IDLE: begin
                    s_next.rx_sub = 4'h0;
                    if (s_reg.rx_prev && !rx_in) begin
                        s_next.rx_state = asr_pkg::ASR_RX_START;
                    end
                end
                asr_pkg::ASR_RX_START: begin
                    if (s_reg.rx_sub == `ASR_HALF_BIT) begin
                        if (rx_in) begin
                            s_next.rx_state = asr_pkg::ASR_RX_IDLE;
                        end
                    end
                    if (s_reg.rx_sub == `ASR_LAST_TICK) begin
                        s_next.rx_bits = 4'h0;
                        s_next.votes = 5'h00;
                        s_next.rx_state = asr_pkg::ASR_RX_DATA;
                    end
                end
                asr_pkg::ASR_RX_DATA: begin
                    if (s_reg.rx_sub == `ASR_LAST_TICK) begin
                        s_next.votes = 5'h00;
                        s_next.rx_shift = s_reg.rx_nine
                            ? {bit_vote, s_reg.rx_shift[8:1]}
                            : {1'b0, bit_vote, s_reg.rx_shift[7:1]};
                        s_next.rx_bits = s_reg.rx_bits + 4'h1;
                        if (s_reg.rx_bits + 4'h1 == data_bits) begin
                            s_next.rx_state = asr_pkg::ASR_RX_STOP;
                        end
                    end
                end
                asr_pkg::ASR_RX_STOP: begin
                    if (s_reg.rx_sub == `ASR_HALF_BIT + 4'h2) begin
                        s_next.rx_state = asr_pkg::ASR_RX_IDLE;
                        if (fi.count == 2'h2 && !fi.pop) begin
                            s_next.overrun = 1'b1;
                        end else begin
                            fi.push = 1'b1;
                            fi.wdata = {!bit_vote, s_reg.rx_shift};
                        end
                    end
                end
                default: begin
                    s_next.rx_state = asr_pkg::ASR_RX_IDLE;
                end
            endcase
        end

        s_next.tx_irq = tx_flag && s_reg.irq_en[`ASR_IE_TX]
            && s_reg.irq_en[`ASR_IE_PERIPHERAL_IRQ_GATE] && s_reg.irq_en[`ASR_IE_GIE];
        s_next.rx_irq = rx_flag && s_reg.irq_en[`ASR_IE_RX]
            && s_reg.irq_en[`ASR_IE_PERIPHERAL_IRQ_GATE] && s_reg.irq_en[`ASR_IE_GIE];
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.tx_line <= 1'b1;
            s_reg.rx_prev <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    logic tx_out_reg;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_out_reg <= 1'b1;
        end else begin
            tx_out_reg <= s_next.tx_line ^ s_next.tx_invert;
        end
    end

    assign tx_out = tx_out_reg;
    assign rdata = s_reg.rdata;
    assign tx_irq = s_reg.tx_irq;
    assign rx_irq = s_reg.rx_irq;
endmodule

// file: asr_serial_port_chk.sv
module asr_serial_port_chk (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic baud_tick,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic rx_in,
    input wire logic tx_out,
    input wire logic tx_irq,
    input wire logic rx_irq
);
    logic [5:0] txc_reg;
    logic [1:0] rxc_reg;
    logic [3:0] ie_reg;
    logic [7:0] low_reg;
    logic tx_gate;
    logic rx_gate;
    // ----
    // Control shadow, ticks per low run
    // ----
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            txc_reg <= 6'h00;
            rxc_reg <= 2'h0;
            ie_reg <= 4'h0;
            low_reg <= 8'h00;
        end else begin
            if (wr_en && addr == 4'h0) txc_reg <= wdata[5:0];
            if (wr_en && addr == 4'h1) rxc_reg <= wdata[1:0];
            if (wr_en && addr == 4'h4) ie_reg <= wdata[3:0];
            low_reg <= tx_out ? 8'h00 : low_reg + {7'h00, baud_tick};
        end
    end
    assign tx_gate = ie_reg[0] & ie_reg[2] & ie_reg[3];
    assign rx_gate = ie_reg[1] & ie_reg[2] & ie_reg[3] & rxc_reg[0]
        & txc_reg[5] & !txc_reg[4];
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    reset_rest_a: assert property (disable iff (1'b0)
        !rstn |=> tx_out && rdata == 8'h00 && !tx_irq && !rx_irq)
        else $error("outputs not at rest after reset");
    rdata_idle_a: assert property (!rd_en |=> rdata == 8'h00)
        else $error("read data outside its slot");
    unmapped_read_a: assert property (
        rd_en && addr > 4'h5 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    tx_irq_gate_a: assert property (
        tx_irq |-> tx_gate || $past(tx_gate))
        else $error("tx irq without enables");
    rx_irq_gate_a: assert property (
        rx_irq |-> rx_gate || $past(rx_gate))
        else $error("rx irq without enables");
    tx_bit_time_a: assert property (
        $rose(tx_out) && !txc_reg[3] |-> low_reg[3:0] == 4'h0
        && low_reg != 8'h00)
        else $error("low run not whole bit times");
    tx_on_tick_a: assert property (
        $changed(tx_out) && !txc_reg[3]
        |-> $past(baud_tick) || $past(baud_tick, 2))
        else $error("tx line moved off a tick");
    busy_status_a: assert property (
        rd_en && addr == 4'h5 && !tx_out && !txc_reg[3] |=> !rdata[0])
        else $error("shift empty set mid frame");
    frame_c: cover property ($fell(tx_out));
    rx_flag_c: cover property ($rose(rx_irq));
    tx_flag_c: cover property ($rose(tx_irq));
    rx_read_c: cover property (rd_en && addr == 4'h3);
endmodule

bind asr_serial_port asr_serial_port_chk chk_i (
    .core_clk(core_clk), .rstn(rstn), .baud_tick(baud_tick),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .rx_in(rx_in), .tx_out(tx_out),
    .tx_irq(tx_irq), .rx_irq(rx_irq)
);

// file: asr_serial_port_tb.sv
module asr_serial_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic nine;
        logic ninth;
        logic stop;
        logic [7:0] data;
    } asr_row_t;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic baud_tick = 1'b0;
    logic [1:0] div_reg = 2'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rdata;
    logic rx_in;
    logic tx_out;
    logic tx_irq;
    logic rx_irq;
    int miscompares = 0;
    int checked = 0;
    asr_row_t r;
    asr_row_t rows [4] = '{
        '{1'b0, 1'b0, 1'b1, 8'ha5}, '{1'b1, 1'b1, 1'b1, 8'h3c},
        '{1'b1, 1'b0, 1'b1, 8'hff}, '{1'b0, 1'b0, 1'b0, 8'h81}};
    asr_serial_port dut (
        .core_clk(core_clk), .rstn(rstn), .baud_tick(baud_tick),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .rx_in(rx_in), .tx_out(tx_out),
        .tx_irq(tx_irq), .rx_irq(rx_irq));
    asr_remote_node peer (.core_clk(core_clk), .baud_tick(baud_tick),
        .tx_out(tx_out), .rx_in(rx_in));
    always #4 core_clk = ~core_clk;
    // Tick every fourth cycle
    always @(posedge core_clk) begin
        div_reg <= div_reg + 2'h1;
        baud_tick <= (div_reg == 2'h3);
    end
    task automatic chk(string n, logic [8:0] s, logic [8:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rc(string n, logic [3:0] a, logic [7:0] m,
                      logic [7:0] e);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk(n, {1'b0, rdata & m}, {1'b0, e});
    endtask
    task automatic got(logic [8:0] e);
        int k;
        k = 0;
        while (peer.seen.size() == 0 && k < 3000) begin
            @(posedge core_clk);
            k++;
        end
        chk("tx frame", peer.seen.size() > 0 ? peer.seen.pop_front()
            : 9'bx, e);
    endtask
    task automatic summarize();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(8 * 60000);
        miscompares++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        chk("idle line", {8'h00, tx_out}, 9'h001);
        rc("status reset", 4'h5, 8'h3f, 8'h01);
        wr(4'h4, 8'h0f);
        wr(4'h0, 8'h20);
        repeat (3) @(posedge core_clk);
        chk("tx irq off", {8'h00, tx_irq}, 9'h000);
        wr(4'h0, 8'h21);
        repeat (3) @(posedge core_clk);
        chk("tx irq on", {8'h00, tx_irq}, 9'h001);
        wr(4'h4, 8'h0b);
        repeat (3) @(posedge core_clk);
        chk("tx irq masked", {8'h00, tx_irq}, 9'h000);
        wr(4'h4, 8'h0f);
        foreach (rows[i]) begin
            r = rows[i];
            wr(4'h0, {5'h04, r.ninth, r.nine, 1'b1});
            wr(4'h1, {6'h00, r.nine, 1'b1});
            wr(4'h2, r.data);
            got({r.nine ? r.ninth : 1'b1, r.data});
            peer.send({r.ninth, r.data}, r.nine ? 9 : 8, r.stop);
            repeat (8) @(posedge core_clk);
            chk("rx irq", {8'h00, rx_irq}, 9'h001);
            rc("rx status", 4'h5, r.nine ? 8'h3f : 8'h1f,
               {2'b00, r.nine & r.ninth, !r.stop, 4'h7});
            rc("rx data", 4'h3, 8'hff, r.data);
            rc("rx empty", 4'h5, 8'h04, 8'h00);
        end
        wr(4'h2, 8'h5a);
        wr(4'h2, 8'hc3);
        repeat (6) @(posedge core_clk);
        rc("busy status", 4'h5, 8'h03, 8'h00);
        got(9'h15a);
        got(9'h1c3);
        repeat (64) @(posedge core_clk);
        rc("shift empty", 4'h5, 8'h03, 8'h03);
        peer.blip(4);
        repeat (200) @(posedge core_clk);
        rc("glitch", 4'h5, 8'h1c, 8'h00);
        for (int j = 0; j < 4; j++) peer.send(9'(8'h10 + j), 8, 1'b1);
        rc("overrun", 4'h5, 8'h0c, 8'h0c);
        rc("first", 4'h3, 8'hff, 8'h10);
        rc("second", 4'h3, 8'hff, 8'h11);
        rc("blocked", 4'h5, 8'h0c, 8'h08);
        wr(4'h1, 8'h00);
        rc("cleared", 4'h5, 8'h08, 8'h00);
        peer.send(9'h0aa, 8, 1'b1);
        rc("rx off", 4'h5, 8'h04, 8'h00);
        wr(4'h1, 8'h01);
        peer.send(9'h055, 8, 1'b1);
        rc("resumed", 4'h3, 8'hff, 8'h55);
        rc("unmapped", 4'hf, 8'hff, 8'h00);
        wr(4'h0, 8'h29);
        repeat (2) @(posedge core_clk);
        #1;
        chk("inverted idle", {8'h00, tx_out}, 9'h000);
        summarize();
    end
endmodule
